// file: hdl/cpmc_pkg.sv
package cpmc_pkg;
    // ==========================================================
    // Register map (byte addresses on the AXI4-Lite bus)
    localparam logic [7:0] CPMC_PWR_CTRL_OFS    = 8'h00;  // power_control_reg
    localparam logic [7:0] CPMC_ANA_EN_OFS      = 8'h04;  // Analog shutdown enables
    localparam logic [7:0] CPMC_WDOG_CTRL_OFS   = 8'h08;  // watchdog_timer control
    localparam logic [7:0] CPMC_MCD_CTRL_OFS    = 8'h0C;  // missing_clock_detector ctrl
    localparam logic [7:0] CPMC_STATUS_OFS      = 8'h10;  // Mode and reset cause
    localparam logic [7:0] CPMC_WAKE_OFS        = 8'h14;  // CPU side: instr done, wake

    // ==========================================================
    // Field positions
    localparam int CPMC_IDLE_BIT  = 0;
    localparam int CPMC_STOP_BIT  = 1;
    localparam int CPMC_FLAGS_LSB = 2;
    localparam int CPMC_FLAGS_MSB = 7;
    localparam int CPMC_WD_EN_BIT   = 0;
    localparam int CPMC_WD_LOCK_BIT = 1;
    localparam int CPMC_WD_KICK_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CPMC_PWR_CTRL_RST = 8'h00;
    localparam logic [7:0] CPMC_ANA_EN_RST   = 8'hFF;
    localparam logic [2:0] CPMC_WDOG_RST     = 3'h1;   // Watchdog enabled after reset
    localparam logic       CPMC_MCD_RST      = 1'b0;
    localparam logic [15:0] CPMC_RESET_PC    = 16'h0000;

    // ==========================================================
    // Timing
    localparam int CPMC_CLK_MHZ     = 100;
    localparam int CPMC_MCD_TMO_US  = 100;
    localparam int CPMC_MCD_CYCLES  = CPMC_MCD_TMO_US * CPMC_CLK_MHZ;
    localparam int CPMC_WDOG_CYCLES = 65536;
    localparam int CPMC_RST_CYCLES  = 4;
    localparam logic [2:0] CPMC_RST_CYC3 = 3'h4;

    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {
        CPMC_RUN   = 2'b00,
        CPMC_IDLE  = 2'b01,
        CPMC_STOP  = 2'b10,
        CPMC_RESET = 2'b11
    } cpmc_mode_t;
endpackage

// file: hdl/cpmc_timeout.sv
`timescale 1ns/100ps
// ==========================================================
// Down counter that pulses once when it runs out
module cpmc_timeout #(
    parameter int LIMIT = 16
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LOAD = W'(LIMIT - 1);

    logic [W-1:0] cnt_q;

    // Count only while running; reload on restart or when idle
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || !run) begin
            cnt_q   <= LOAD;
            expired <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q   <= LOAD;
            expired <= 1'b1;
        end else begin
            cnt_q   <= cnt_q - 1'b1;
            expired <= 1'b0;
        end
    end
endmodule

// file: hdl/cpmc_core.sv
`timescale 1ns/100ps
// What this block does
// (RULE_01) Idle halts only the CPU; clocks and peripherals keep running.
// (RULE_02) Stop halts CPU, timers, interrupts, internal oscillator; missing-clock detector stays.
// (RULE_03) Writing one to power bit 0 enters Idle after the writing instruction.
// (RULE_04) Registers and memory keep their contents during Idle.
// (RULE_05) Idle ends only on an enabled interrupt or any reset.
// (RULE_06) Interrupt wake clears the idle bit and lets the CPU resume.
// (RULE_07) Pending interrupt is serviced, then return continues after the idle write.
// (RULE_08) Reset ending Idle runs reset sequence and starts at address zero.
// (RULE_09) Enabled watchdog counts in Idle and its reset ends Idle.
// (RULE_10) Watchdog can be disabled before Idle only when its lock permits.
// (RULE_11) Writing one to power bit 1 enters Stop after the writing instruction.
// (RULE_12) Each analog peripheral, external oscillator included, has its own shutdown.
// (RULE_13) Only a reset ends Stop; then reset sequence and start at zero.
// (RULE_14) Enabled missing-clock detector resets the core while in Stop.
// (RULE_15) Software should disable the detector before Stops longer than 100 us.
// (RULE_16) Once oscillators are off, only a reset restarts; interrupts cannot.
// (RULE_17) Bits 7 to 2 are plain read-write general flags without effect.
// (RULE_18) Idle and stop bits read zero; writing zero changes nothing.
module cpmc_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        instr_done,
    input  wire logic        irq_pending,
    input  wire logic        ext_reset_n,
    output logic             cpu_run,
    output logic             periph_clk_en,
    output logic             int_osc_en,
    output logic             irq_gate_en,
    output logic [7:0]       analog_en,
    output logic             core_reset,
    output logic [15:0]      reset_pc
);
    import cpmc_pkg::*;

    // ==========================================================
    // State
    cpmc_mode_t  mode_q;
    logic [5:0]  flags_q;
    logic        idle_req_q;
    logic        stop_req_q;
    logic [7:0]  ana_q;
    logic        wd_en_q;
    logic        wd_lock_q;
    logic        mcd_en_q;
    logic [2:0]  rst_cnt_q;
    logic [1:0]  cause_q;
    logic        ext_sync1_q;
    logic        ext_sync2_q;
    logic        irq_sync1_q;
    logic        irq_sync2_q;
    logic        wd_expired;
    logic        mcd_expired;
    logic        wd_kick;

    // ==========================================================
    // AXI4-Lite write channel: address and data taken in any order
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // Hold each channel once taken until the response goes out
    // Ready is a one-cycle pulse, so a held valid is taken exactly once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q[1:0] != 2'b00 ||
                                 aw_addr_q > CPMC_WAKE_OFS) ? 2'b10 : 2'b00;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only byte lane 0 carries writable bits; a write without it is ignored
    logic wr_pwr;
    logic wr_ana;
    logic wr_wd;
    logic wr_mcd;
    assign wr_pwr = wr_fire && aw_addr_q == CPMC_PWR_CTRL_OFS && w_strb_q[0];
    assign wr_ana = wr_fire && aw_addr_q == CPMC_ANA_EN_OFS && w_strb_q[0];
    assign wr_wd  = wr_fire && aw_addr_q == CPMC_WDOG_CTRL_OFS && w_strb_q[0];
    assign wr_mcd = wr_fire && aw_addr_q == CPMC_MCD_CTRL_OFS && w_strb_q[0];
    assign wd_kick = wr_wd && w_data_q[CPMC_WD_KICK_BIT];

    // ==========================================================
    // Pin synchronisers: first stage read only by the second
    // Reset pin idles high, so the stages start high to avoid a false reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync1_q <= 1'b1;
            ext_sync2_q <= 1'b1;
            irq_sync1_q <= 1'b0;
            irq_sync2_q <= 1'b0;
        end else begin
            ext_sync1_q <= ext_reset_n;
            ext_sync2_q <= ext_sync1_q;
            irq_sync1_q <= irq_pending;
            irq_sync2_q <= irq_sync1_q;
        end
    end

    // ==========================================================
    // Power control register: command bits plus general flags
    always_ff @(posedge aclk) begin
        if (!aresetn || mode_q == CPMC_RESET) begin
            flags_q    <= CPMC_PWR_CTRL_RST[CPMC_FLAGS_MSB:CPMC_FLAGS_LSB];
            idle_req_q <= 1'b0;
            stop_req_q <= 1'b0;
        end else begin
            // Requests are consumed once the mode is entered
            if (mode_q == CPMC_RUN && instr_done) begin
                idle_req_q <= 1'b0;
                stop_req_q <= 1'b0;
            end
            // A write landing with a retire comes last, so the new request wins
            if (wr_pwr) begin
                flags_q <= w_data_q[CPMC_FLAGS_MSB:CPMC_FLAGS_LSB];  // see RULE_17
                // Writing zero leaves a pending request alone  see RULE_18
                if (w_data_q[CPMC_IDLE_BIT]) idle_req_q <= 1'b1;    // see RULE_03
                if (w_data_q[CPMC_STOP_BIT]) stop_req_q <= 1'b1;    // see RULE_11
            end
        end
    end

    // ==========================================================
    // Analog shutdowns, watchdog and detector controls
    // Analog writes are taken in run only, so none can race a stop entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ana_q <= CPMC_ANA_EN_RST;
        end else if (wr_ana && mode_q == CPMC_RUN) begin
            ana_q <= w_data_q[7:0];                                 // see RULE_12
        end
    end

    // Lock is sticky until reset so a stray write cannot kill the watchdog
    always_ff @(posedge aclk) begin
        if (!aresetn || mode_q == CPMC_RESET) begin
            wd_en_q   <= CPMC_WDOG_RST[CPMC_WD_EN_BIT];
            wd_lock_q <= CPMC_WDOG_RST[CPMC_WD_LOCK_BIT];
            mcd_en_q  <= CPMC_MCD_RST;
        end else begin
            if (wr_wd) begin
                if (w_data_q[CPMC_WD_EN_BIT] || !wd_lock_q) begin
                    wd_en_q <= w_data_q[CPMC_WD_EN_BIT];            // see RULE_10
                end
                if (w_data_q[CPMC_WD_LOCK_BIT]) wd_lock_q <= 1'b1;
            end
            if (wr_mcd) mcd_en_q <= w_data_q[0];
        end
    end

    // A kick write reloads the count; while disabled it rests at its load value
    // Watchdog counts in run and idle, reloaded to its load value in stop  see RULE_09
    cpmc_timeout #(.LIMIT(CPMC_WDOG_CYCLES)) u_wdog (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (wd_en_q && (mode_q == CPMC_RUN || mode_q == CPMC_IDLE)),
        .restart (wd_kick),
        .expired (wd_expired)
    );

    // Limitation: the detector counts aclk cycles and does not watch a real edge
    // Detector times the stopped oscillator  see RULE_14
    cpmc_timeout #(.LIMIT(CPMC_MCD_CYCLES)) u_mcd (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (mcd_en_q && mode_q == CPMC_STOP),
        .restart (1'b0),
        .expired (mcd_expired)
    );

    // ==========================================================
    // Mode sequencer
    // Any reset source outranks every mode, stop included
    logic any_reset;
    assign any_reset = !ext_sync2_q || wd_expired || mcd_expired;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q    <= CPMC_RESET;
            rst_cnt_q <= 3'h0;
            cause_q   <= 2'b00;
        end else if (any_reset && mode_q != CPMC_RESET) begin
            mode_q    <= CPMC_RESET;                           // see RULE_08, RULE_13
            rst_cnt_q <= 3'h0;
            cause_q   <= {mcd_expired, wd_expired};
        end else begin
            unique case (mode_q)
                CPMC_RUN: begin
                    // Enter only once the writing instruction has retired
                    // Stop outranks idle when both requests wait on the same retire
                    if (instr_done && stop_req_q)      mode_q <= CPMC_STOP;  // see RULE_11
                    else if (instr_done && idle_req_q) mode_q <= CPMC_IDLE;  // see RULE_03
                end
                CPMC_IDLE: begin
                    // CPU resumes into the handler; return lands after the write
                    if (irq_sync2_q) mode_q <= CPMC_RUN;         // see RULE_05, RULE_06, RULE_07
                end
                CPMC_STOP: begin
                    mode_q <= CPMC_STOP;                         // see RULE_16
                end
                CPMC_RESET: begin
                    // A held reset pin keeps the sequence at its start
                    if (!ext_sync2_q) rst_cnt_q <= 3'h0;
                    else if (rst_cnt_q == CPMC_RST_CYC3) mode_q <= CPMC_RUN;
                    else rst_cnt_q <= rst_cnt_q + 3'h1;
                end
            endcase
        end
    end

    // ==========================================================
    // Gating outputs; clocks stay on in idle and state is untouched
    // Mode outputs lag the mode by one cycle, but they always move together; analog_en lags ana_q instead
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_run       <= 1'b0;
            periph_clk_en <= 1'b1;
            int_osc_en    <= 1'b1;
            irq_gate_en   <= 1'b0;
            analog_en     <= CPMC_ANA_EN_RST;
            core_reset    <= 1'b1;
            reset_pc      <= CPMC_RESET_PC;
        end else begin
            cpu_run       <= mode_q == CPMC_RUN;                 // see RULE_01, RULE_04
            periph_clk_en <= mode_q != CPMC_STOP;                // see RULE_02
            int_osc_en    <= mode_q != CPMC_STOP;                // see RULE_02
            irq_gate_en   <= mode_q == CPMC_RUN || mode_q == CPMC_IDLE;
            analog_en     <= ana_q;                              // see RULE_12
            core_reset    <= mode_q == CPMC_RESET;               // see RULE_13
            reset_pc      <= CPMC_RESET_PC;                      // see RULE_08
        end
    end

    // ==========================================================
    // AXI4-Lite read channel, one cycle answer
    // Address is looked at only on the handshake edge, where it must still stand
    logic [31:0] rd_val;
    always_comb begin
        unique case (s_axi_araddr)
            CPMC_PWR_CTRL_OFS:  rd_val = {24'h0, flags_q, 2'b00};        // see RULE_18
            CPMC_ANA_EN_OFS:    rd_val = {24'h0, ana_q};
            CPMC_WDOG_CTRL_OFS: rd_val = {30'h0, wd_lock_q, wd_en_q};
            CPMC_MCD_CTRL_OFS:  rd_val = {31'h0, mcd_en_q};
            CPMC_STATUS_OFS:    rd_val = {28'h0, cause_q, mode_q};
            default:            rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= (s_axi_araddr[1:0] != 2'b00 ||
                                 s_axi_araddr > CPMC_STATUS_OFS) ? 2'b10 : 2'b00;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: sim/cpmc_monitor.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks of the power mode sequencer
module cpmc_monitor (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        instr_done,
    input  wire logic        irq_pending,
    input  wire logic        cpu_run,
    input  wire logic        periph_clk_en,
    input  wire logic        int_osc_en,
    input  wire logic        irq_gate_en,
    input  wire logic        core_reset,
    input  wire logic [15:0] reset_pc
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // CPU halted, clocks up, sequencer not resetting
    logic idle_w;
    assign idle_w = !cpu_run && periph_clk_en && !core_reset;
    // Four quiet cycles flush the two request sync stages
    sequence s_quiet_idle;
        (idle_w && !irq_pending)[*4];
    endsequence
    sequence s_stop;
        !periph_clk_en && !core_reset;
    endsequence
    idle_clocks_a: assert property (idle_w |-> int_osc_en && irq_gate_en)
        else $error("idle stopped a clock");
    stop_gates_a: assert property (!periph_clk_en |-> !cpu_run && !int_osc_en && !irq_gate_en)
        else $error("stop left something running");
    entry_after_instr_a: assert property ($fell(cpu_run) && !core_reset |->
        $past(instr_done) || $past(instr_done, 2))
        else $error("halt without retired instruction");
    idle_holds_a: assert property (s_quiet_idle |=> !cpu_run)
        else $error("idle ended without cause");
    idle_wake_a: assert property (idle_w && irq_pending |-> ##[1:8] (cpu_run || core_reset))
        else $error("no wake on interrupt");
    stop_exit_reset_a: assert property (s_stop |=> !periph_clk_en || core_reset)
        else $error("stop left without reset");
    reset_vector_a: assert property (core_reset |-> !cpu_run && reset_pc == 16'h0000)
        else $error("bad reset state");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
endmodule

bind cpmc_core cpmc_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .instr_done(instr_done),
    .irq_pending(irq_pending), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
    .int_osc_en(int_osc_en), .irq_gate_en(irq_gate_en), .core_reset(core_reset),
    .reset_pc(reset_pc)
);

// file: sim/cpmc_core_tb.sv
`timescale 1ns/100ps
module cpmc_core_tb;
    import cpmc_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic        aclk = 1'h0, aresetn = 1'h0, instr_done = 1'h0, irq_pending = 1'h0;
    logic        ext_reset_n = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, analog_en;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cpu_run, periph_clk_en, int_osc_en, irq_gate_en, core_reset;
    logic [15:0] reset_pc;
    int          fail_count = 0, total_checks = 0;

    cpmc_core uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .instr_done(instr_done), .irq_pending(irq_pending),
        .ext_reset_n(ext_reset_n), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
        .int_osc_en(int_osc_en), .irq_gate_en(irq_gate_en), .analog_en(analog_en),
        .core_reset(core_reset), .reset_pc(reset_pc)
    );

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // Checking and closing
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic give_up(input string nm);
        fail_count++;
        $display("BAD %s expected done seen timeout", nm);
        finish_test();
    endtask

    // ==========================================================
    // AXI4-Lite master; ready is looked at mid-cycle, where it is settled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hit, w_hit, b_hit;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bready && s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'h0;
            if (w_hit) s_axi_wvalid <= 1'h0;
            if (b_hit) begin
                s_axi_bready <= 1'h0;
                return;
            end
        end
        give_up("write response");
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit, r_hit;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rready && s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hit) s_axi_arvalid <= 1'h0;
            if (r_hit) begin
                s_axi_rready <= 1'h0;
                return;
            end
        end
        give_up("read data");
    endtask

    // Bounded wait on cpu_run (sel 0) or core_reset (sel 1)
    task automatic wait_out(input int sel, input logic val, input int lim, input string nm);
        for (int i = 0; i < lim; i++) begin
            @(negedge aclk);
            if ((sel == 0 ? cpu_run : core_reset) === val) return;
        end
        give_up(nm);
    endtask

    // One retired instruction
    task automatic retire();
        @(posedge aclk);
        instr_done <= 1'h1;
        @(posedge aclk);
        instr_done <= 1'h0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        wait_out(0, 1'h1, 50, "boot");
        axi_rd(CPMC_PWR_CTRL_OFS, rd, rsp);
        chk("power reg reset", 32'(CPMC_PWR_CTRL_RST), rd);
        axi_rd(CPMC_ANA_EN_OFS, rd, rsp);
        chk("analog reset", 32'h000000FF, rd);
        chk("reset pc", 32'h0, 32'(reset_pc));
        axi_wr(CPMC_PWR_CTRL_OFS, 32'h000000A8, rsp);
        axi_rd(CPMC_PWR_CTRL_OFS, rd, rsp);
        chk("flags", 32'h000000A8, rd);
        axi_wr(CPMC_ANA_EN_OFS, 32'h0000005A, rsp);
        @(negedge aclk);
        chk("analog_en", 32'h0000005A, 32'(analog_en));
        axi_rd(8'h40, rd, rsp);
        chk("unmapped read", 32'h2, 32'(rsp));
        axi_wr(8'h40, 32'h0, rsp);
        chk("unmapped write", 32'h2, 32'(rsp));
        $display("test registers done");
        // Idle: held until the writing instruction retires
        axi_wr(CPMC_PWR_CTRL_OFS, 32'h000000A9, rsp);
        @(negedge aclk);
        chk("run before retire", 32'h1, 32'(cpu_run));
        retire();
        wait_out(0, 1'h0, 10, "idle entry");
        chk("idle clocks", 32'h3, 32'({periph_clk_en, int_osc_en}));
        axi_rd(CPMC_PWR_CTRL_OFS, rd, rsp);
        chk("idle keeps flags", 32'h000000A8, rd);
        axi_rd(CPMC_STATUS_OFS, rd, rsp);
        chk("mode idle", 32'h1, 32'(rd[1:0]));
        retire();
        repeat (10) @(posedge aclk);
        chk("idle holds", 32'h0, 32'(cpu_run));
        irq_pending <= 1'h1;
        wait_out(0, 1'h1, 20, "idle wake");
        @(posedge aclk);
        irq_pending <= 1'h0;
        axi_rd(CPMC_STATUS_OFS, rd, rsp);
        chk("mode run", 32'h0, 32'(rd[1:0]));
        $display("test idle done");
        // Stop: interrupts cannot end it, a reset pin does
        axi_rd(CPMC_MCD_CTRL_OFS, rd, rsp);
        chk("detector off before stop", 32'h0, rd);
        axi_wr(CPMC_PWR_CTRL_OFS, 32'h00000002, rsp);
        retire();
        wait_out(0, 1'h0, 10, "stop entry");
        chk("stop gates", 32'h0, 32'({periph_clk_en, int_osc_en, irq_gate_en}));
        @(posedge aclk);
        irq_pending <= 1'h1;
        repeat (20) @(posedge aclk);
        chk("stop ignores irq", 32'h0, 32'({cpu_run, periph_clk_en}));
        irq_pending <= 1'h0;
        ext_reset_n <= 1'h0;
        wait_out(1, 1'h1, 20, "pin reset");
        @(posedge aclk);
        ext_reset_n <= 1'h1;
        wait_out(0, 1'h1, 50, "restart");
        axi_rd(CPMC_PWR_CTRL_OFS, rd, rsp);
        chk("flags after reset", 32'h0, rd);
        $display("test stop done");
        // Missing clock detector ends stop
        axi_wr(CPMC_MCD_CTRL_OFS, 32'h1, rsp);
        axi_wr(CPMC_PWR_CTRL_OFS, 32'h2, rsp);
        retire();
        wait_out(0, 1'h0, 10, "stop entry");
        wait_out(1, 1'h1, CPMC_MCD_CYCLES + 100, "detector");
        wait_out(0, 1'h1, 50, "restart");
        axi_rd(CPMC_STATUS_OFS, rd, rsp);
        chk("detector cause", 32'h1, 32'(rd[3]));
        $display("test detector done");
        // Watchdog ends idle, then disabling only while unlocked
        axi_wr(CPMC_PWR_CTRL_OFS, 32'h1, rsp);
        retire();
        wait_out(0, 1'h0, 10, "idle entry");
        wait_out(1, 1'h1, CPMC_WDOG_CYCLES + 100, "watchdog");
        wait_out(0, 1'h1, 50, "restart");
        axi_rd(CPMC_STATUS_OFS, rd, rsp);
        chk("watchdog cause", 32'h1, 32'(rd[2]));
        axi_wr(CPMC_WDOG_CTRL_OFS, 32'h0, rsp);
        axi_rd(CPMC_WDOG_CTRL_OFS, rd, rsp);
        chk("watchdog off", 32'h0, 32'(rd[1:0]));
        axi_wr(CPMC_WDOG_CTRL_OFS, 32'h3, rsp);
        axi_wr(CPMC_WDOG_CTRL_OFS, 32'h0, rsp);
        axi_rd(CPMC_WDOG_CTRL_OFS, rd, rsp);
        chk("watchdog locked", 32'h3, 32'(rd[1:0]));
        $display("test watchdog done");
        finish_test();
    end
endmodule
